//--- src/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic push, pop;

  // Pointers carry one extra bit so that full and empty are told apart.
  assign level = wr_q - rd_q;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

//--- src/id_decode.sv
// Decodes the fifth and sixth identifier bytes into plain fields.
// Purely combinational; the caller registers whatever it presents.
`timescale 1ns/10ps
module id_decode (
  input wire logic [7:0] byte5,
  input wire logic [7:0] byte6,
  output logic [3:0] planes,
  output logic [4:0] ecc_bits,
  output logic [11:0] ecc_sector,
  output logic ecc_rsvd,
  output logic [1:0] node,
  output logic node_rsvd,
  output logic edo,
  output logic ddr,
  output logic pad_ok
);
  // Plane count is a power of two in bits 3:2.
  always_comb begin
    planes = 4'h1 << byte5[3:2];
    ecc_rsvd = 1'b0;
    ecc_sector = 12'h200;
    ecc_bits = 5'h18;
    case (byte5[6:4])
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: ecc_bits = 5'h01 << byte5[6:4];
      3'h5: ecc_sector = 12'h800;
      3'h6: ecc_sector = 12'h400;
      default: begin
        ecc_bits = 5'h00;
        ecc_rsvd = 1'b1;
      end
    endcase
  end

  // Technology, EDO and interface from the sixth byte; reserved bits must be zero.
  assign node = byte6[1:0];
  assign node_rsvd = byte6[2] || (byte6[1:0] == 2'h3);
  assign edo = byte6[6];
  assign ddr = byte6[7];
  assign pad_ok = !byte5[7] && (byte5[1:0] == 2'h0) && (byte6[5:3] == 3'h0);
endmodule

//--- src/nand_host.sv
// NAND flash host controller: APB register slave, bus-cycle sequencer for the
// NAND strobes and I/O bus, read-data FIFO, and command sequence checking.
// Assumes the NAND pins are synchronous to mclk; the bench takes io_in straight from the die model, which has no io_oe input.
// Summary of operation
// - Command byte latched at WE rise with CLE high, CE and ALE low, not busy; the sequencer also issues FFh, 70h and 78h while busy.
// - Data byte latched at WE rise with CLE, CE and ALE low, not busy.
// - During reads hold CLE low, WE high, ALE low, WP high; toggle RE.
// - Random data output column changes stay inside the current page.
// - Multi-plane and cache reads use identical page addresses on both planes.
// - Multi-plane random data out only after a multi-plane read loaded both planes.
// - Multi-plane reads only on pages written by a multi-plane program.
// - All pages of one cache read stay in the same block.
// - Close multi-plane cache reads with the end command, else reset first.
// - Keep a minimum gap between last address WE rise and first data WE rise.
// - Identifier readout is 90h, address 00h, then six read strobes.
// - 31h continues a cache read, 3Fh ends it without a further page.
`timescale 1ns/10ps
module nand_host #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic busy_n
);
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_SETUP, S_LOW, S_HIGH} state_t;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  state_t state_q;
  logic [7:0] cnt_q, adl_q, op_byte_q, last_cmd_q, page_q;
  logic [1:0] op_kind_q, mp_cnt_q;
  logic [nand_host_pkg::CNT_W-1:0] op_cnt_q;
  logic [2:0] cfg_q, addr_cnt_q, id_idx_q;
  logic [13:0] col_q, col_new_q;
  logic [2:0][7:0] row_a_q, row_b_q;
  logic [7:0] id5_q, id6_q;
  logic cache_q, mp_loaded_q, id_mode_q, id_valid_q, err_q;
  logic push_q;
  logic [7:0] push_data_q;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [3:0] id_planes;
  logic [4:0] id_ecc_bits;
  logic [11:0] id_ecc_sector;
  logic [1:0] id_node;
  logic id_ecc_rsvd, id_node_rsvd, id_edo, id_ddr, id_pad_ok;
  logic access, wr_commit, rd_commit, op_commit, launch, refuse, exempt, go;
  logic [7:0] wbyte;
  logic [1:0] wkind;
  logic [31:0] rdata_d;

  // Commands the device accepts while busy.
  function automatic logic busy_ok(input logic [7:0] c);
    busy_ok = (c == nand_host_pkg::CMD_RESET) || (c == nand_host_pkg::CMD_STATUS) ||
              (c == nand_host_pkg::CMD_MP_STATUS);
  endfunction

  // APB phases: one wait state, the write or pop happens on the pready edge.
  assign access = psel && penable;
  assign wr_commit = access && pready && pwrite;
  assign rd_commit = access && pready && !pwrite && (paddr == nand_host_pkg::OFS_DATA);
  assign op_commit = wr_commit && (paddr == nand_host_pkg::OFS_OP);
  assign wbyte = pwdata[7:0];
  assign wkind = pwdata[nand_host_pkg::OP_KIND_LSB +: 2];
  assign launch = op_commit && (state_q == S_IDLE) && !refuse;

  // Sequence checks made when software posts a cycle; a refused cycle never reaches the pins.
  always_comb begin
    refuse = 1'b0;
    if (wkind == nand_host_pkg::KIND_CMD) begin
      case (wbyte)
        nand_host_pkg::CMD_MP_SETUP: refuse = !cfg_q[1];
        nand_host_pkg::CMD_READ_CONF, nand_host_pkg::CMD_MP_CONF:
          refuse = (mp_cnt_q == 2'h2) && (row_a_q != row_b_q);
        nand_host_pkg::CMD_RAND_OUT:
          refuse = (last_cmd_q == nand_host_pkg::CMD_READ) && (addr_cnt_q == 3'h5) &&
                   !mp_loaded_q;
        nand_host_pkg::CMD_RAND_CONF: refuse = (col_new_q >= nand_host_pkg::PAGE_BYTES);
        nand_host_pkg::CMD_CACHE_NEXT: refuse = (page_q == nand_host_pkg::LAST_PAGE);
        default: refuse = 1'b0;
      endcase
      // Inside a cache read only the cache, status, read and reset commands may pass.
      if (cache_q && !(busy_ok(wbyte) || wbyte == nand_host_pkg::CMD_CACHE_NEXT ||
          wbyte == nand_host_pkg::CMD_CACHE_END || wbyte == nand_host_pkg::CMD_READ)) begin
        refuse = 1'b1;
      end
    end else if (wkind == nand_host_pkg::KIND_ADDR) begin
      if (last_cmd_q == nand_host_pkg::CMD_RAND_OUT && addr_cnt_q >= 3'h2) begin
        refuse = 1'b1;
      end
      if (last_cmd_q == nand_host_pkg::CMD_MP_SETUP && addr_cnt_q >= 3'h3) begin
        refuse = 1'b1;
      end
    end
  end

  // A cycle starts once the device is ready (exempt commands and status reads need not wait), data-in after the address gap, data-out with FIFO room.
  assign exempt = (op_kind_q == nand_host_pkg::KIND_CMD && busy_ok(op_byte_q)) ||
                  (op_kind_q == nand_host_pkg::KIND_DOUT &&
                   (last_cmd_q == nand_host_pkg::CMD_STATUS ||
                    last_cmd_q == nand_host_pkg::CMD_MP_STATUS));
  assign go = (busy_n || exempt) &&
              !(op_kind_q == nand_host_pkg::KIND_DIN && adl_q != 8'h00) &&
              !(op_kind_q == nand_host_pkg::KIND_DOUT && !fifo_in_ready);

  // Configuration register: bit 0 WP# level, bit 1 multi-plane programmed, bit 2 hold CE#.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= nand_host_pkg::CFG_RESET;
    end else if (wr_commit && paddr == nand_host_pkg::OFS_CFG) begin
      cfg_q <= pwdata[2:0];
    end
  end

  // Sticky refusal flag; a new refusal wins over a write-one clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (op_commit && (state_q != S_IDLE || refuse)) begin
      err_q <= 1'b1;
    end else if (wr_commit && paddr == nand_host_pkg::OFS_STAT &&
                 pwdata[nand_host_pkg::ST_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // Bus-cycle sequencer; every NAND pin is a flop so no glitch reaches the device.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q <= 8'h00;
      op_kind_q <= nand_host_pkg::KIND_CMD;
      op_byte_q <= 8'h00;
      op_cnt_q <= '0;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      wp_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      push_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          wp_n <= cfg_q[0];
          if (launch) begin
            op_kind_q <= wkind;
            op_byte_q <= wbyte;
            op_cnt_q <= pwdata[nand_host_pkg::OP_CNT_LSB +: nand_host_pkg::CNT_W];
            state_q <= S_WAIT;
          end
        end
        // Setup: control levels and write data settle before any strobe falls.
        S_WAIT: begin
          if (go) begin
            ce_n <= 1'b0;
            cle <= (op_kind_q == nand_host_pkg::KIND_CMD);
            ale <= (op_kind_q == nand_host_pkg::KIND_ADDR);
            io_out <= op_byte_q;
            io_oe <= (op_kind_q != nand_host_pkg::KIND_DOUT);
            if (op_kind_q == nand_host_pkg::KIND_DOUT) begin
              wp_n <= 1'b1;
            end
            cnt_q <= 8'(nand_host_pkg::SETUP_CYC);
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_q <= 8'h01) begin
            if (op_kind_q == nand_host_pkg::KIND_DOUT) begin
              re_n <= 1'b0;
            end else begin
              we_n <= 1'b0;
            end
            cnt_q <= 8'(nand_host_pkg::LO_CYC);
            state_q <= S_LOW;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        // End of the low phase: WE# rise latches, or read data is taken before RE# rises.
        S_LOW: begin
          if (cnt_q <= 8'h01) begin
            we_n <= 1'b1;
            re_n <= 1'b1;
            if (op_kind_q == nand_host_pkg::KIND_DOUT) begin
              push_q <= 1'b1;
              push_data_q <= io_in;
            end
            cnt_q <= 8'(nand_host_pkg::HI_CYC);
            state_q <= S_HIGH;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        // High phase doubles as hold time; reads loop until the count is spent.
        S_HIGH: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (op_kind_q == nand_host_pkg::KIND_DOUT && op_cnt_q > 1) begin
            op_cnt_q <= op_cnt_q - 1'b1;
            state_q <= S_WAIT;
          end else begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            ce_n <= !cfg_q[2];
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Address-to-data gap counter, restarted at every address WE# rise.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adl_q <= 8'h00;
    end else if (state_q == S_LOW && cnt_q <= 8'h01 && op_kind_q == nand_host_pkg::KIND_ADDR) begin
      adl_q <= 8'(nand_host_pkg::ADL_CYC);
    end else if (adl_q != 8'h00) begin
      adl_q <= adl_q - 8'h01;
    end
  end

  // Command-sequence tracking, updated as each command or address cycle is posted.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_cmd_q <= nand_host_pkg::CMD_RESET;
      addr_cnt_q <= 3'h0;
      mp_cnt_q <= 2'h0;
      mp_loaded_q <= 1'b0;
      cache_q <= 1'b0;
      id_mode_q <= 1'b0;
      page_q <= 8'h00;
      col_new_q <= 14'h0000;
      row_a_q <= '0;
      row_b_q <= '0;
    end else if (launch && wkind == nand_host_pkg::KIND_CMD) begin
      last_cmd_q <= wbyte;
      addr_cnt_q <= 3'h0;
      id_mode_q <= (wbyte == nand_host_pkg::CMD_ID);
      case (wbyte)
        nand_host_pkg::CMD_RESET: begin
          cache_q <= 1'b0;
          mp_loaded_q <= 1'b0;
          mp_cnt_q <= 2'h0;
        end
        nand_host_pkg::CMD_MP_SETUP: mp_cnt_q <= (mp_cnt_q == 2'h2) ? 2'h1 : mp_cnt_q + 2'h1;
        nand_host_pkg::CMD_READ_CONF, nand_host_pkg::CMD_MP_CONF: begin
          mp_loaded_q <= (mp_cnt_q == 2'h2);
          mp_cnt_q <= 2'h0;
        end
        nand_host_pkg::CMD_CACHE_NEXT: begin
          cache_q <= 1'b1;
          page_q <= page_q + 8'h01;
        end
        nand_host_pkg::CMD_CACHE_END: cache_q <= 1'b0;
        default: cache_q <= cache_q;
      endcase
    end else if (launch && wkind == nand_host_pkg::KIND_ADDR) begin
      addr_cnt_q <= addr_cnt_q + 3'h1;
      if (last_cmd_q == nand_host_pkg::CMD_MP_SETUP) begin
        if (mp_cnt_q == 2'h1) begin
          row_a_q[addr_cnt_q[1:0]] <= wbyte;
        end else begin
          row_b_q[addr_cnt_q[1:0]] <= wbyte;
        end
      end else if (addr_cnt_q == 3'h0) begin
        col_new_q[7:0] <= wbyte;
      end else if (addr_cnt_q == 3'h1) begin
        col_new_q[13:8] <= wbyte[5:0];
      end else if (addr_cnt_q == 3'h2) begin
        page_q <= wbyte;
      end
    end
  end

  // Column pointer mirror: loaded at confirm, zeroed by cache commands, stepped per RE#.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      col_q <= 14'h0000;
    end else if (launch && wkind == nand_host_pkg::KIND_CMD &&
                 (wbyte == nand_host_pkg::CMD_CACHE_NEXT ||
                  wbyte == nand_host_pkg::CMD_CACHE_END)) begin
      col_q <= 14'h0000;
    end else if (launch && wkind == nand_host_pkg::KIND_CMD &&
                 (wbyte == nand_host_pkg::CMD_READ_CONF ||
                  wbyte == nand_host_pkg::CMD_RAND_CONF)) begin
      col_q <= col_new_q;
    end else if (push_q && !id_mode_q) begin
      col_q <= col_q + 14'h0001;
    end
  end

  // Identifier capture: count reads after 90h/00h and keep the fifth and sixth bytes.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      id_idx_q <= 3'h0;
      id5_q <= 8'h00;
      id6_q <= 8'h00;
      id_valid_q <= 1'b0;
    end else if (launch && wkind == nand_host_pkg::KIND_ADDR && id_mode_q) begin
      id_idx_q <= 3'h0;
      id_valid_q <= 1'b0;
      if (wbyte != nand_host_pkg::ID_ADDR) begin
        id_idx_q <= 3'h7;
      end
    end else if (push_q && id_mode_q && id_idx_q != 3'h7) begin
      id_idx_q <= id_idx_q + 3'h1;
      if (id_idx_q == nand_host_pkg::ID_IDX_5TH) begin
        id5_q <= push_data_q;
      end
      if (id_idx_q == nand_host_pkg::ID_IDX_6TH) begin
        id6_q <= push_data_q;
        id_valid_q <= 1'b1;
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(rd_commit),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  id_decode u_id (
    .byte5(id5_q),
    .byte6(id6_q),
    .planes(id_planes),
    .ecc_bits(id_ecc_bits),
    .ecc_sector(id_ecc_sector),
    .ecc_rsvd(id_ecc_rsvd),
    .node(id_node),
    .node_rsvd(id_node_rsvd),
    .edo(id_edo),
    .ddr(id_ddr),
    .pad_ok(id_pad_ok)
  );

  // Read data mux; unmapped offsets read zero and answer with an error.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      nand_host_pkg::OFS_OP: rdata_d = {2'h0, op_cnt_q, 6'h00, op_kind_q, op_byte_q};
      nand_host_pkg::OFS_STAT: rdata_d = {16'h0000, 5'h00, id_valid_q, LW'(fifo_level),
                                          err_q, mp_loaded_q, cache_q, busy_n,
                                          (state_q != S_IDLE)} & 32'h0000_FFFF;
      nand_host_pkg::OFS_DATA: rdata_d = {23'h000000, fifo_out_valid, fifo_out_data};
      nand_host_pkg::OFS_CFG: rdata_d = {29'h00000000, cfg_q};
      nand_host_pkg::OFS_ID: rdata_d = {3'h0, id_valid_q, id_pad_ok, id_ddr, id_edo,
                                        id_node_rsvd, id_node, id_ecc_sector, id_ecc_rsvd,
                                        id_ecc_bits, id_planes};
      nand_host_pkg::OFS_COL: rdata_d = {18'h00000, col_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // APB answer flops: pready rises one cycle into the access phase and lasts one cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= (paddr > nand_host_pkg::OFS_COL) || (paddr[1:0] != 2'h0);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

//--- src/nand_host_pkg.sv
// Shared constants for the NAND flash host controller: timing, register map,
// register fields and the NAND command codes that the sequencer watches.
// Assumes a 200 MHz mclk; every cycle count below is derived from a time in ns.
package nand_host_pkg;

  // Clock rate and strobe timing; least times round up to whole cycles.
  localparam int CLK_MHZ = 200;
  localparam int T_SETUP_NS = 15;
  localparam int T_STROBE_LO_NS = 15;
  localparam int T_STROBE_HI_NS = 15;
  localparam int T_ADL_NS = 100;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int LO_CYC = (T_STROBE_LO_NS * CLK_MHZ + 999) / 1000;
  localparam int HI_CYC = (T_STROBE_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int ADL_CYC = (T_ADL_NS * CLK_MHZ + 999) / 1000;

  // Register byte offsets on the APB side.
  localparam logic [7:0] OFS_OP = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0C;
  localparam logic [7:0] OFS_ID = 8'h10;
  localparam logic [7:0] OFS_COL = 8'h14;

  // Operation register fields and kinds of bus cycle.
  localparam int OP_KIND_LSB = 8;
  localparam int OP_CNT_LSB = 16;
  localparam int CNT_W = 14;
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_DIN = 2'h2;
  localparam logic [1:0] KIND_DOUT = 2'h3;

  // Status, configuration and data register bits.
  localparam int ST_ERR_BIT = 4;
  localparam int DATA_VALID_BIT = 8;
  localparam logic [2:0] CFG_RESET = 3'h1;

  // Command codes that the sequencer tracks.
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_RAND_OUT = 8'h05;
  localparam logic [7:0] CMD_READ_CONF = 8'h30;
  localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
  localparam logic [7:0] CMD_MP_CONF = 8'h33;
  localparam logic [7:0] CMD_CACHE_END = 8'h3F;
  localparam logic [7:0] CMD_MP_SETUP = 8'h60;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_MP_STATUS = 8'h78;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RAND_CONF = 8'hE0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ID_ADDR = 8'h00;

  // Page geometry and identifier byte positions (0-based read index).
  localparam logic [13:0] PAGE_BYTES = 14'h21C0;
  localparam logic [7:0] LAST_PAGE = 8'hFF;
  localparam logic [2:0] ID_IDX_5TH = 3'h4;
  localparam logic [2:0] ID_IDX_6TH = 3'h5;

endpackage

//--- tb/nand_dev_model.sv
// Behavioural flash die on the far side of the NAND host controller.
// Assumes strobes come from the host; no clock, cycles are framed by the strobes.
`timescale 1ns/10ps
module nand_dev_model #(
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEVID = 8'h3C // Arbitrary value.
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic busy_n
);
  logic [7:0] idb [6];
  logic [13:0] col = 14'h0, cola = 14'h0;
  logic [2:0] idx = 3'h0, acnt = 3'h0;
  logic idm = 1'b0;
  logic [7:0] dout;
  // Identifier table; bytes five and six carry the decoded fields.
  initial begin
    idb = '{MAKER, DEVID, 8'h11, 8'h22, 8'h64, 8'h41};
    busy_n = 1'b1;
  end
  // Commands and addresses latch at the write strobe rise.
  always @(posedge we_n) begin
    if (!ce_n && cle && !ale) begin
      idm = (io_out == 8'h90);
      idx = 3'h0;
      acnt = 3'h0;
      if (io_out == 8'h31 || io_out == 8'h3F) col = 14'h0;
      if (io_out == 8'h30 || io_out == 8'hE0) col = cola;
      if (io_out == 8'h30 || io_out == 8'h31) begin
        busy_n = 1'b0;
        #200 busy_n = 1'b1;
      end
    end else if (!ce_n && ale && !cle) begin
      if (acnt == 3'h0) cola[7:0] = io_out;
      if (acnt == 3'h1) cola[13:8] = io_out[5:0];
      acnt = acnt + 3'h1;
    end
  end
  // Each read strobe rise moves on to the next byte.
  always @(posedge re_n) begin
    if (!ce_n && idm) idx = idx + 3'h1;
    else if (!ce_n) col = col + 14'h1;
  end
  assign dout = idm ? idb[idx] : col[7:0];
  // A released bus shows the inverse, so a stale byte never passes for data.
  assign io_in = (!ce_n && !re_n) ? dout : ~dout;
endmodule

//--- tb/nand_host_asserts.sv
// Pin-level checks of the NAND host, seeing only its top-level ports.
// Assumes the single mclk domain with synchronous active-low rst_n.
`timescale 1ns/10ps
module nand_host_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic busy_n
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Cycles since the last address strobe rise; saturates over long idle spells.
  logic [7:0] gap_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || ($rose(we_n) && ale)) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  AST_CMD_LATCH: assert property ($rose(we_n) && cle |-> !ce_n && !ale && io_oe)
    else $error("command strobe without proper qualifiers");
  AST_DIN_LATCH: assert property ($rose(we_n) && !cle && !ale |-> !ce_n && io_oe && busy_n)
    else $error("data strobe while busy or deselected");
  AST_READ_PINS: assert property (!re_n |-> !cle && !ale && we_n && wp_n && !io_oe)
    else $error("read strobe with wrong pin levels");
  AST_STROBE_CE: assert property (!re_n || !we_n |-> !ce_n)
    else $error("strobe without chip enable");
  AST_WE_WIDTH: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
    else $error("write strobe low time wrong");
  AST_RE_WIDTH: assert property ($fell(re_n) |-> !re_n [*3] ##1 re_n)
    else $error("read strobe low time wrong");
  AST_IO_HOLD: assert property ($fell(we_n) |-> $stable(io_out) [*4])
    else $error("byte changed under write strobe");
  AST_IDLE_PINS: assert property (ce_n |-> we_n && re_n && !io_oe)
    else $error("activity while deselected");
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("register answer not after one wait");
  AST_ADL_GAP: assert property ($rose(we_n) && !cle && !ale |-> gap_q >= 8'h13)
    else $error("data strobe too soon after address");
endmodule

//--- tb/tb_top.sv
// Self-checking bench: APB master, NAND die model and pin checker.
// Assumes mclk at 200 MHz and the register map of the host package.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); err_count++; end end
module tb_top;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, busy_n, serr;
  logic [7:0] io_out, io_in;
  int err_count = 0, tests_run = 0, cyc = 0;
  nand_host #(.FIFO_DEPTH(16)) dut_u (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .busy_n(busy_n));
  nand_dev_model dev_u (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_out(io_out), .io_in(io_in), .busy_n(busy_n));
  always #2.5 mclk = ~mclk;
  // A hang is cut short well beyond the thousand or so cycles the run needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Setup cycle, then access held until pready is seen at a rising edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One NAND cycle order, then poll until the sequencer is idle again.
  task automatic op(input logic [1:0] k, input logic [7:0] b, input logic [13:0] n);
    apb(nand_host_pkg::OFS_OP, 1'b1, {2'b00, n, 6'h00, k, b});
    rd = 32'h1;
    for (int i = 0; i < 300 && rd[0] !== 1'b0; i++) apb(nand_host_pkg::OFS_STAT, 1'b0, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] b);
    op(nand_host_pkg::KIND_CMD, b, 14'h0);
  endtask
  task automatic adr(input logic [7:0] b);
    op(nand_host_pkg::KIND_ADDR, b, 14'h0);
  endtask
  task automatic pop(input logic [7:0] e);
    apb(nand_host_pkg::OFS_DATA, 1'b0, 32'h0);
    `CHK(rd[8:0], {1'b1, e})
  endtask
  // Identifier readout in order, then the decoded fields of bytes five and six.
  task automatic t_id();
    cmd(8'h90);
    adr(8'h00);
    op(nand_host_pkg::KIND_DOUT, 8'h00, 14'h6);
    foreach (dev_u.idb[i]) pop(dev_u.idb[i]);
    apb(nand_host_pkg::OFS_ID, 1'b0, 32'h0);
    `CHK(rd, 32'h1A500182)
  endtask
  // Page read from column 10h, cache continue and end restart at column 0.
  task automatic t_read();
    cmd(8'h00);
    adr(8'h10);
    adr(8'h00);
    adr(8'h01);
    adr(8'h02);
    adr(8'h00);
    cmd(8'h30);
    op(nand_host_pkg::KIND_DOUT, 8'h00, 14'h3);
    for (int i = 0; i < 3; i++) pop(8'h10 + 8'(i));
    cmd(8'h31);
    op(nand_host_pkg::KIND_DOUT, 8'h00, 14'h2);
    for (int i = 0; i < 2; i++) pop(8'(i));
    cmd(8'h80);
    `CHK(rd[4], 1'b1)
    apb(nand_host_pkg::OFS_STAT, 1'b1, 32'h10);
    cmd(8'h3F);
    apb(nand_host_pkg::OFS_OP, 1'b1, {2'b00, 14'h14, 6'h00, nand_host_pkg::KIND_DOUT, 8'h00});
    for (int i = 0; i < 300 && rd[9:5] !== 5'h10; i++) apb(nand_host_pkg::OFS_STAT, 1'b0, 32'h0);
    `CHK(rd[9:5], 5'h10)
    for (int i = 0; i < 20; i++) pop(8'(i));
    apb(nand_host_pkg::OFS_DATA, 1'b0, 32'h0);
    `CHK(rd[8], 1'b0)
  endtask
  // Refused multi-plane setup, an unmapped address, then a program data byte.
  task automatic t_refuse();
    cmd(8'h60);
    `CHK(rd[4], 1'b1)
    apb(8'h40, 1'b0, 32'h0);
    `CHK({serr, rd}, 33'h100000000)
    apb(nand_host_pkg::OFS_STAT, 1'b1, 32'h10);
    cmd(8'h80);
    for (int i = 0; i < 5; i++) adr(8'h00);
    op(nand_host_pkg::KIND_DIN, 8'hC3, 14'h0);
    cmd(8'hFF);
    `CHK(rd[4], 1'b0)
  endtask
  // Reset is held for 16 cycles, then the scenarios run in turn.
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    `CHK({ce_n, cle, ale, we_n, re_n, wp_n, io_oe}, 7'b1001110)
    t_id();
    t_read();
    t_refuse();
    tally_and_finish();
  end
endmodule
bind nand_host nand_host_asserts chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
  .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .busy_n(busy_n));
